/* File: inc/osd_line_attr_consts.vh */
// Constants for the OSD line attribute register bank
`ifndef OSD_LINE_ATTR_CONSTS_VH
`define OSD_LINE_ATTR_CONSTS_VH

// Register word indices; the byte address is the index times four
`define IDX_CSIZE4 12'hF9A
`define IDX_CSIZE8 12'hF9B
`define IDX_CSIZE12 12'hF9C
`define IDX_ULINE8 12'hF9D
`define IDX_ULINE12 12'hF9E
`define IDX_FRINGE8 12'hF9F
`define IDX_FRINGE12 12'hFA0
`define IDX_DOTCLK 12'hFA1
`define IDX_SOLID4 12'hFA2
`define IDX_SOLID8 12'hFA3
`define IDX_SOLID12 12'hFA4
`define IDX_BGFR 12'hFA5
`define IDX_AREA 12'hFA6
`define ADDR_W 14
`define WORD_SHIFT 2

// Reset values
`define RST_BYTE 8'h00
`define RST_PAIRS 24'h000000
`define RST_LINES 12'h000
`define RST_CODE 4'h0
`define RST_BIT 1'b0

// Character size codes
`define CSIZE_OFF 2'h0
`define CSIZE_LARGE 2'h1
`define CSIZE_MIDDLE 2'h2
`define CSIZE_SMALL 2'h3

// Fringe growth in dots
`define FRINGE_GROW_NONE 2'h0
`define FRINGE_GROW_NORMAL 2'h1
`define FRINGE_GROW_SMALL 2'h2

// Colour code fields
`define COL_HI_MSB 7
`define COL_HI_LSB 4
`define COL_LO_MSB 3
`define COL_LO_LSB 0
`define COL_INTENSITY 3

`define NUM_LINES 12
`define UNUSED_READ 32'h0000_0000

`endif

/* File: src/fringe_extent.v */
// Per-line fringe growth and overlap cancel
`timescale 1ns/1ps
`include "osd_line_attr_consts.vh"
module fringe_extent (
    // Line attributes
    input wire [23:0] size_i,
    input wire [11:0] fringe_i,
    // Vertical start gap to next line, one when abutting
    input wire [11:0] no_gap_i,
    // Results
    output wire [23:0] grow_o,
    output wire [11:0] cancel_o
);
    genvar g;
    generate
        for (g = 0; g < `NUM_LINES; g = g + 1) begin : gl
            wire [1:0] sz;
            assign sz = size_i[2*g+1:2*g];
            // Fringe adds one dot, two for small characters
            assign grow_o[2*g+1:2*g] = !fringe_i[g] ? `FRINGE_GROW_NONE :
                (sz == `CSIZE_SMALL) ? `FRINGE_GROW_SMALL : `FRINGE_GROW_NORMAL;
            if (g == 0) begin : first
                assign cancel_o[g] = 1'b0;
            end else begin : rest
                // Line overlapped by a fringed predecessor is cancelled
                assign cancel_o[g] = fringe_i[g-1] && no_gap_i[g-1]
                    && (size_i[2*g-1:2*g-2] != `CSIZE_OFF);
            end
        end
    endgenerate
endmodule // fringe_extent

/* File: src/colour_decode.v */
// Decode a four-bit palette code into intensity and RGB
`timescale 1ns/1ps
`include "osd_line_attr_consts.vh"
module colour_decode (
    // Palette code
    input wire [3:0] code_i,
    // Decoded colour
    output wire bright_o,
    output wire [2:0] rgb_o
);
    // Top bit clear gives bright set, set gives dark set
    assign bright_o = ~code_i[`COL_INTENSITY];
    assign rgb_o = code_i[2:0];
endmodule // colour_decode

/* File: src/osd_line_attribute_regs.v */
// OSD line attribute registers with a classic Wishbone slave
//
// What this block does
// - Two-bit size per line: 00 blank, 01 large, 10 middle, 11 small.
// - One underline bit per line; one shows underline.
// - One fringe-enable bit per line; one draws fringe outline.
// - Fringe grows line height by one dot, two for small characters.
// - Fringe overlap into an abutting next line cancels that next line.
// - Eight-bit read-only lock monitor read at the dot-clock address.
// - Eight-bit write-only dot-clock setting written at that same address.
// - Two-bit solid-space per line: none, left, right, both.
// - Background four-bit code; top bit clear bright, set dark.
// - Fringe colour four-bit code from the same palette.
// - Area 1 and area 2 plane colours from the same palette.
`timescale 1ns/1ps
`include "osd_line_attr_consts.vh"
module osd_line_attribute_regs (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [`ADDR_W-1:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Dot clock lock state from the oscillator domain
    input wire [7:0] dot_clk_lock_mon_i,
    // Vertical start abutting flags per line from the position logic
    input wire [11:0] no_gap_i,
    // Attributes to the rendering engine
    output reg [23:0] line_char_size_o,
    output reg [11:0] line_underline_en_o,
    output reg [11:0] line_fringe_en_o,
    output reg [23:0] line_solid_pad_o,
    output reg [7:0] dot_clk_freq_set_o,
    output reg [3:0] bg_colour_o,
    output reg [3:0] fringe_colour_o,
    output reg [3:0] area1_colour_o,
    output reg [3:0] area2_colour_o,
    output reg [23:0] line_fringe_grow_o,
    output reg [11:0] line_cancel_o,
    output reg bg_bright_o,
    output reg fringe_bright_o
);
    reg [7:0] csize4;
    reg [7:0] csize8;
    reg [7:0] csize12;
    reg [7:0] uline8;
    reg [3:0] uline12;
    reg [7:0] fringe8;
    reg [3:0] fringe12;
    reg [7:0] dotclk;
    reg [7:0] solid4;
    reg [7:0] solid8;
    reg [7:0] solid12;
    reg [7:0] bgfr;
    reg [7:0] area;
    reg [7:0] lock_meta;
    reg [7:0] lock_sync;
    reg [31:0] next_dat;
    wire req;
    wire wr;
    wire [11:0] idx;
    wire [23:0] grow;
    wire [11:0] cancel;
    wire bg_bright;
    wire fr_bright;

    // Word index from byte address
    function [11:0] word_idx;
        input [`ADDR_W-1:0] a;
        begin
            word_idx = a[`ADDR_W-1:`WORD_SHIFT];
        end
    endfunction

    // Register select decode, shared by writes and reads
    function reg_hit;
        input [11:0] a;
        input [11:0] r;
        begin
            reg_hit = (a == r);
        end
    endfunction

    // Whole-register write only when the low lane is selected
    assign req = cyc_i && stb_i && !ack_o;
    assign wr = req && we_i && sel_i[0];
    assign idx = word_idx(adr_i);

    fringe_extent u_fringe (
        .size_i({csize12, csize8, csize4}),
        .fringe_i({fringe12, fringe8}),
        .no_gap_i(no_gap_i),
        .grow_o(grow),
        .cancel_o(cancel)
    );

    colour_decode u_bg (
        .code_i(bgfr[`COL_HI_MSB:`COL_HI_LSB]),
        .bright_o(bg_bright),
        .rgb_o()
    );

    colour_decode u_fr (
        .code_i(bgfr[`COL_LO_MSB:`COL_LO_LSB]),
        .bright_o(fr_bright),
        .rgb_o()
    );

    // Lock monitor crosses from the oscillator domain
    always @(posedge clk_i) begin
        if (rst_i) begin
            lock_meta <= `RST_BYTE;
            lock_sync <= `RST_BYTE;
        end else begin
            lock_meta <= dot_clk_lock_mon_i;
            lock_sync <= lock_meta;
        end
    end

    // Register writes hold until the next write
    always @(posedge clk_i) begin
        if (rst_i) begin
            csize4 <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_CSIZE4)) begin
            csize4 <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            csize8 <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_CSIZE8)) begin
            csize8 <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            csize12 <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_CSIZE12)) begin
            csize12 <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            uline8 <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_ULINE8)) begin
            uline8 <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            uline12 <= `RST_CODE;
        end else if (wr && reg_hit(idx, `IDX_ULINE12)) begin
            uline12 <= dat_i[3:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            fringe8 <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_FRINGE8)) begin
            fringe8 <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            fringe12 <= `RST_CODE;
        end else if (wr && reg_hit(idx, `IDX_FRINGE12)) begin
            fringe12 <= dat_i[3:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            dotclk <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_DOTCLK)) begin
            dotclk <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            solid4 <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_SOLID4)) begin
            solid4 <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            solid8 <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_SOLID8)) begin
            solid8 <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            solid12 <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_SOLID12)) begin
            solid12 <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            bgfr <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_BGFR)) begin
            bgfr <= dat_i[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            area <= `RST_BYTE;
        end else if (wr && reg_hit(idx, `IDX_AREA)) begin
            area <= dat_i[7:0];
        end
    end

    // Read data: only the lock monitor is readable
    always @* begin
        next_dat = `UNUSED_READ;
        if (reg_hit(idx, `IDX_DOTCLK)) begin
            next_dat = {24'h000000, lock_sync};
        end
    end

    // Bus answer one cycle after request
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= `UNUSED_READ;
        end else begin
            ack_o <= req;
            dat_o <= (req && !we_i) ? next_dat : `UNUSED_READ;
        end
    end

    // Attribute outputs to the rendering engine
    always @(posedge clk_i) begin
        if (rst_i) begin
            line_char_size_o <= `RST_PAIRS;
        end else begin
            line_char_size_o <= {csize12, csize8, csize4};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            line_underline_en_o <= `RST_LINES;
        end else begin
            line_underline_en_o <= {uline12, uline8};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            line_fringe_en_o <= `RST_LINES;
        end else begin
            line_fringe_en_o <= {fringe12, fringe8};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            line_solid_pad_o <= `RST_PAIRS;
        end else begin
            line_solid_pad_o <= {solid12, solid8, solid4};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            dot_clk_freq_set_o <= `RST_BYTE;
        end else begin
            dot_clk_freq_set_o <= dotclk;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            bg_colour_o <= `RST_CODE;
        end else begin
            bg_colour_o <= bgfr[`COL_HI_MSB:`COL_HI_LSB];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            fringe_colour_o <= `RST_CODE;
        end else begin
            fringe_colour_o <= bgfr[`COL_LO_MSB:`COL_LO_LSB];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            area1_colour_o <= `RST_CODE;
        end else begin
            area1_colour_o <= area[`COL_LO_MSB:`COL_LO_LSB];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            area2_colour_o <= `RST_CODE;
        end else begin
            area2_colour_o <= area[`COL_HI_MSB:`COL_HI_LSB];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            line_fringe_grow_o <= `RST_PAIRS;
        end else begin
            line_fringe_grow_o <= grow;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            line_cancel_o <= `RST_LINES;
        end else begin
            line_cancel_o <= cancel;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            bg_bright_o <= `RST_BIT;
        end else begin
            bg_bright_o <= bg_bright;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            fringe_bright_o <= `RST_BIT;
        end else begin
            fringe_bright_o <= fr_bright;
        end
    end
endmodule // osd_line_attribute_regs

/* File: testbench/osd_attr_props.sv */
// Assertions on the OSD attribute register ports
`timescale 1ns/1ps
`include "osd_line_attr_consts.vh"
module osd_attr_props (
    // Clock, reset and bus
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [`ADDR_W-1:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // Attributes
    input wire [7:0] dot_clk_lock_mon_i,
    input wire [11:0] no_gap_i,
    input wire [23:0] line_char_size_o,
    input wire [11:0] line_fringe_en_o,
    input wire [7:0] dot_clk_freq_set_o,
    input wire [3:0] bg_colour_o,
    input wire [23:0] line_fringe_grow_o,
    input wire [11:0] line_cancel_o,
    input wire bg_bright_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = cyc_i && stb_i && !ack_o;
    wire dck = adr_i == {`IDX_DOTCLK, 2'h0};
    a_ack_answer: assert property (take |=> ack_o) else $error("no ack");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_lock_read: assert property (take && !we_i && dck && $stable(dot_clk_lock_mon_i)
        && $past(dot_clk_lock_mon_i) == $past(dot_clk_lock_mon_i, 2)
        && $past(dot_clk_lock_mon_i, 2) == $past(dot_clk_lock_mon_i, 3)
        |=> dat_o[7:0] == $past(dot_clk_lock_mon_i)) else $error("lock read");
    a_wo_read_zero: assert property (take && !we_i && !dck |=> dat_o == 32'h0)
        else $error("wo read");
    a_freq_write: assert property (take && we_i && sel_i[0] && dck
        |=> ##1 dot_clk_freq_set_o == $past(dat_i[7:0], 2)) else $error("freq");
    a_grow_small: assert property (line_fringe_en_o[0] && line_char_size_o[1:0] == 2'h3
        && $stable(line_fringe_en_o[0]) && $stable(line_char_size_o[1:0])
        |-> line_fringe_grow_o[1:0] == 2'h2) else $error("grow small");
    a_grow_none: assert property (!line_fringe_en_o[0] && $stable(line_fringe_en_o[0])
        |-> line_fringe_grow_o[1:0] == 2'h0) else $error("grow none");
    a_bright_inv: assert property ($changed(bg_colour_o) ##1 $stable(bg_colour_o)
        |-> bg_bright_o == !bg_colour_o[3]) else $error("bright");
    a_cancel_first: assert property (!line_cancel_o[0]) else $error("cancel0");
    a_cancel_abut: assert property (line_cancel_o[1] == (line_fringe_en_o[0]
        && $past(no_gap_i[0]) && line_char_size_o[1:0] != 2'h0)) else $error("cancel1");
endmodule // osd_attr_props
bind osd_line_attribute_regs osd_attr_props props (.*);

/* File: testbench/core_bus_model.sv */
// Processor core model issuing classic Wishbone cycles
`timescale 1ns/1ps
module core_bus_model (
    // Clock and answer
    input wire clk_i,
    input wire ack_i,
    input wire [31:0] dat_i,
    // Request
    output reg cyc_o,
    output reg stb_o,
    output reg we_o,
    output reg [3:0] sel_o,
    output reg [13:0] adr_o,
    output reg [31:0] dat_o
);
    initial begin
        cyc_o = 0;
        stb_o = 0;
        we_o = 0;
        sel_o = 0;
        adr_o = 0;
        dat_o = 0;
    end
    // Whole-byte transfers only, never read-modify-write
    task xfer(input w, input [3:0] s, input [11:0] i, input [7:0] d, output [7:0] q);
        begin
            @(posedge clk_i);
            cyc_o <= 1;
            stb_o <= 1;
            we_o <= w;
            sel_o <= s;
            adr_o <= {i, 2'h0};
            dat_o <= {24'h0, d};
            @(posedge clk_i);
            while (!ack_i) begin
                @(posedge clk_i);
            end
            q = dat_i[7:0];
            cyc_o <= 0;
            stb_o <= 0;
            sel_o <= 4'h0;
            adr_o <= ~adr_o;
            dat_o <= ~dat_o;
        end
    endtask
endmodule // core_bus_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the OSD line attribute registers
`timescale 1ns/1ps
`include "osd_line_attr_consts.vh"
module tb_top;
    reg clk_i = 0;
    reg rst_i = 1;
    reg [7:0] lock = 8'h00;
    reg [11:0] gap = 12'h000;
    wire cyc, stb, we, ack, bgb, frb;
    wire [3:0] sel;
    wire [13:0] adr;
    wire [31:0] wd, rd_d;
    wire [23:0] size, grow, solid;
    wire [11:0] ul, fen, cn;
    wire [7:0] freq;
    wire [3:0] bg, fr, a1, a2;
    integer fails = 0;
    integer tests_run = 0;
    integer c;
    reg [7:0] q;
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    core_bus_model core (.clk_i(clk_i), .ack_i(ack), .dat_i(rd_d), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wd));
    osd_line_attribute_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd_d), .ack_o(ack),
        .dot_clk_lock_mon_i(lock), .no_gap_i(gap), .line_char_size_o(size),
        .line_underline_en_o(ul), .line_fringe_en_o(fen), .line_solid_pad_o(solid),
        .dot_clk_freq_set_o(freq), .bg_colour_o(bg), .fringe_colour_o(fr),
        .area1_colour_o(a1), .area2_colour_o(a2), .line_fringe_grow_o(grow),
        .line_cancel_o(cn), .bg_bright_o(bgb), .fringe_bright_o(frb));
    task chk(input string n, input [63:0] e, input [63:0] g);
        begin
            tests_run = tests_run + 1;
            if (e !== g) begin
                fails = fails + 1;
                $display("Error %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task wr(input [11:0] i, input [7:0] d);
        begin
            core.xfer(1'b1, 4'h1, i, d, q);
            repeat (3) @(posedge clk_i);
            #1;
        end
    endtask
    task rd(input string n, input [11:0] i, input [7:0] e);
        begin
            core.xfer(1'b0, 4'h1, i, 8'h00, q);
            chk(n, e, q);
        end
    endtask
    task t_size;
        begin
            wr(`IDX_FRINGE8, 8'hFF);
            wr(`IDX_FRINGE12, 8'h0F);
            chk("fringe", 12'hFFF, fen);
            for (c = 0; c < 4; c = c + 1) begin
                wr(`IDX_CSIZE4, {4{c[1:0]}});
                chk("size", {4{c[1:0]}}, size[7:0]);
                chk("grow", (c == 3) ? 2 : 1, grow[1:0]);
            end
            wr(`IDX_CSIZE8, 8'hE4);
            wr(`IDX_CSIZE12, 8'h1B);
            chk("size hi", 16'h1BE4, size[23:8]);
            chk("grow hi", 16'h5695, grow[23:8]);
            wr(`IDX_FRINGE8, 8'hFE);
            chk("grow off", 2'h0, grow[1:0]);
        end
    endtask
    task t_cancel;
        begin
            @(posedge clk_i);
            gap <= 12'h001;
            wr(`IDX_CSIZE4, 8'h55);
            wr(`IDX_FRINGE8, 8'h00);
            chk("no cancel", 12'h000, cn);
            wr(`IDX_FRINGE8, 8'h01);
            chk("cancel", 12'h002, cn);
        end
    endtask
    task t_misc;
        begin
            wr(`IDX_ULINE8, 8'hA5);
            wr(`IDX_ULINE12, 8'h0C);
            chk("underline", 12'hCA5, ul);
            wr(`IDX_SOLID4, 8'h1B);
            wr(`IDX_SOLID8, 8'hE4);
            wr(`IDX_SOLID12, 8'hC6);
            chk("solid", 24'hC6E41B, solid);
            wr(`IDX_BGFR, 8'h17);
            wr(`IDX_AREA, 8'hC3);
            chk("colours a", 18'h05CF3, {bg, fr, a1, a2, bgb, frb});
            wr(`IDX_BGFR, 8'h9A);
            wr(`IDX_AREA, 8'h8B);
            chk("colours b", 18'h26AE0, {bg, fr, a1, a2, bgb, frb});
        end
    endtask
    task t_dotclk;
        begin
            @(posedge clk_i);
            lock <= 8'h5A;
            wr(`IDX_DOTCLK, 8'h3C);
            chk("freq", 8'h3C, freq);
            core.xfer(1'b1, 4'h0, `IDX_DOTCLK, 8'h77, q);
            repeat (3) @(posedge clk_i);
            #1;
            chk("no lane", 8'h3C, freq);
            rd("lock", `IDX_DOTCLK, 8'h5A);
            rd("wo read", `IDX_ULINE8, 8'h00);
            rd("unmapped", 12'h100, 8'h00);
            wr(12'h100, 8'hFF);
            chk("hold", 20'h3CCA5, {freq, ul});
        end
    endtask
    task end_of_test;
        begin
            if (fails == 0 && tests_run > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    initial begin
        #100000;
        fails = fails + 1;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        #1;
        chk("reset", 48'h0, {size, ul, fen});
        chk("reset2", 48'h0, {solid, freq, bg, fr, a1, a2});
        t_size;
        t_cancel;
        t_misc;
        t_dotclk;
        end_of_test;
    end
endmodule // tb_top
